// ### common/dda_consts.svh
// dda_consts.svh: register addresses, bit positions, command codes and reset values
// assumes: included by the package and by the design modules
`ifndef DDA_CONSTS_SVH
`define DDA_CONSTS_SVH

// task-file addresses {cs1_n_in==0 selects the control block}
`define DDA_ADDR_DATA 3'h0
`define DDA_ADDR_ERROR 3'h1
`define DDA_ADDR_FEAT 3'h1
`define DDA_ADDR_COUNT 3'h2
`define DDA_ADDR_SECTOR 3'h3
`define DDA_ADDR_CYL_LO 3'h4
`define DDA_ADDR_CYL_HI 3'h5
`define DDA_ADDR_DRVHEAD 3'h6
`define DDA_ADDR_STATUS 3'h7
`define DDA_ADDR_COMMAND 3'h7
`define DDA_ADDR_ALTSTAT 3'h6
`define DDA_ADDR_DIAG 3'h7

// status bits
`define DDA_ST_BSY 7
`define DDA_ST_DRDY 6
`define DDA_ST_DF 5
`define DDA_ST_ERR 0
// error bit
`define DDA_ER_ABORTED 2
// drive/head bits
`define DDA_DH_DRV 4
`define DDA_DH_HEAD_LSB 0
`define DDA_DH_HEAD_MSB 3
// diagnostic bits
`define DDA_DG_HIZ 7
`define DDA_DG_WGATE 6
`define DDA_DG_HEAD_LSB 2
`define DDA_DG_HEAD_MSB 5
`define DDA_DG_SEC 1
`define DDA_DG_PRI 0

// command codes
`define DDA_CMD_NOP 8'h00

// reset values
`define DDA_RST_BYTE 8'h00
`define DDA_RST_ONE_BYTE 8'h01
`define DDA_RST_DRVHEAD 8'hA0
`define DDA_RST_STATUS 8'h50
`define DDA_MASK_HEAD 4'hF

// cycles a supported command stays busy before completion
`define DDA_EXEC_CYCLES 4'h4

`endif

// ### common/dda_pkg.sv
// dda_pkg.sv: types used by the command engine of the task-file top
// assumes: dda_consts.svh is on the include path
package dda_pkg;
    `include "dda_consts.svh"
    typedef enum logic [1:0] {
        DDA_IDLE,
        DDA_EXEC,
        DDA_DONE
    } dda_cmd_state_type;

    typedef enum logic [1:0] {
        DDA_RES_ABORT,
        DDA_RES_OK
    } dda_result_type;
endpackage

// ### rtl/dda_diag_reg.sv
// dda_diag_reg.sv: read-only diagnostic byte, built live from drive state
// assumes: inputs synchronous to clk_sys_in; caller gates bit 7 drive
module dda_diag_reg
    import dda_pkg::*;
(
    input wire logic media_write_gate_n_in,
    input wire logic [3:0] head_num_in,
    input wire logic drive_sel_in,
    input wire logic slave_cfg_in,
    input wire logic active_in,
    output logic [7:0] diag_out
);
    `include "dda_consts.svh"
    logic this_selected;
    // not latched: recomputed every read
    always_comb begin
        this_selected = (drive_sel_in == slave_cfg_in) && active_in;
        diag_out = `DDA_RST_BYTE;
        diag_out[`DDA_DG_HIZ] = 1'b0;
        diag_out[`DDA_DG_WGATE] = media_write_gate_n_in;
        diag_out[`DDA_DG_HEAD_MSB:`DDA_DG_HEAD_LSB] = ~head_num_in;
        diag_out[`DDA_DG_SEC] = ~(this_selected && slave_cfg_in);
        diag_out[`DDA_DG_PRI] = ~(this_selected && !slave_cfg_in);
    end
endmodule // dda_diag_reg

// ### rtl/dda_cmd_decode.sv
// dda_cmd_decode.sv: classifies a command code as nop, supported or unknown
// assumes: purely combinational, used by the task-file top
module dda_cmd_decode
    import dda_pkg::*;
(
    input wire logic [7:0] code_in,
    output logic is_nop_out,
    output logic supported_out
);
    `include "dda_consts.svh"
    function automatic logic known(input logic [7:0] c);
        case (c[7:4])
            4'h1, 4'h7: known = 1'b1;
            4'h2, 4'h3: known = (c[3:2] == 2'b00) || (c == 8'h3C);
            4'h4: known = (c[3:1] == 3'b000);
            4'h5: known = (c == 8'h50);
            4'h9: known = (c[3:0] <= 4'h9);
            4'hB: known = (c == 8'hB0);
            4'hC: known = (c >= 8'hC4) && (c <= 8'hCB) && (c != 8'hC7);
            4'hE: known = (c <= 8'hE8) || (c == 8'hEC) || (c == 8'hEF);
            4'hF: known = ((c >= 8'hF1) && (c <= 8'hF6)) || (c == 8'hF8) || (c == 8'hF9);
            default: known = 1'b0;
        endcase
    endfunction
    always_comb begin
        is_nop_out = (code_in == `DDA_CMD_NOP);
        supported_out = known(code_in);
    end
endmodule // dda_cmd_decode

// ### rtl/dda_task_file.sv
// dda_task_file.sv: drive task-file port with diagnostic register and command engine
// assumes: host strobes are one-cycle, synchronous to clk_sys_in; data transfers
// and real command work live elsewhere, supported commands complete after a delay
module dda_task_file
    import dda_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic cs0_n_in,
    input wire logic cs1_n_in,
    input wire logic [2:0] addr_in,
    input wire logic rd_stb_in,
    input wire logic wr_stb_in,
    input wire logic [7:0] data_in,
    input wire logic media_write_gate_n_in,
    input wire logic slave_cfg_in,
    output logic [7:0] data_out,
    output logic [7:0] data_oe_out,
    output logic intrq_out,
    output logic [7:0] drive_head_select_reg_out
);
    `include "dda_consts.svh"
    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0] status_q;
    logic [7:0] error_q;
    logic [7:0] feat_q;
    logic [7:0] count_q;
    logic [7:0] sector_q;
    logic [7:0] cyl_lo_q;
    logic [7:0] cyl_hi_q;
    logic [7:0] drvhead_q;
    logic [3:0] exec_cnt_q;
    dda_cmd_state_type state_q;
    dda_result_type result_q;
    logic [7:0] data_q;
    logic [7:0] oe_q;
    logic intrq_q;
    logic [7:0] diag_byte;
    logic cmd_is_nop;
    logic cmd_supported;
    logic sel_cmd;
    logic cmd_wr;
    logic selected;

    function automatic logic hit(input logic cs0_n, input logic cs1_n,
                                 input logic [2:0] a, input logic [2:0] want,
                                 input logic block);
        hit = block ? (!cs1_n && cs0_n && a == want) : (!cs0_n && cs1_n && a == want);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    dda_diag_reg i_dda_diag_reg (
        .media_write_gate_n_in(media_write_gate_n_in),
        .head_num_in(drvhead_q[`DDA_DH_HEAD_MSB:`DDA_DH_HEAD_LSB]),
        .drive_sel_in(drvhead_q[`DDA_DH_DRV]),
        .slave_cfg_in(slave_cfg_in),
        .active_in(1'b1),
        .diag_out(diag_byte)
    );

    dda_cmd_decode i_dda_cmd_decode (
        .code_in(data_in),
        .is_nop_out(cmd_is_nop),
        .supported_out(cmd_supported)
    );

    assign selected = (drvhead_q[`DDA_DH_DRV] == slave_cfg_in);
    assign sel_cmd = hit(cs0_n_in, cs1_n_in, addr_in, `DDA_ADDR_COMMAND, 1'b0);
    // busy drive ignores commands; host must wait anyway
    assign cmd_wr = wr_stb_in && sel_cmd && selected
        && !status_q[`DDA_ST_BSY] && status_q[`DDA_ST_DRDY];

    ////////////////////////////////////////////////////////////////////////////////
    // parameter registers: only host writes touch them, no command does
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            feat_q <= `DDA_RST_BYTE;
            count_q <= `DDA_RST_ONE_BYTE;
            sector_q <= `DDA_RST_ONE_BYTE;
            cyl_lo_q <= `DDA_RST_BYTE;
            cyl_hi_q <= `DDA_RST_BYTE;
            drvhead_q <= `DDA_RST_DRVHEAD;
        end else if (wr_stb_in && !status_q[`DDA_ST_BSY]) begin
            if (hit(cs0_n_in, cs1_n_in, addr_in, `DDA_ADDR_FEAT, 1'b0)) begin
                feat_q <= data_in;
            end
            if (hit(cs0_n_in, cs1_n_in, addr_in, `DDA_ADDR_COUNT, 1'b0)) begin
                count_q <= data_in;
            end
            if (hit(cs0_n_in, cs1_n_in, addr_in, `DDA_ADDR_SECTOR, 1'b0)) begin
                sector_q <= data_in;
            end
            if (hit(cs0_n_in, cs1_n_in, addr_in, `DDA_ADDR_CYL_LO, 1'b0)) begin
                cyl_lo_q <= data_in;
            end
            if (hit(cs0_n_in, cs1_n_in, addr_in, `DDA_ADDR_CYL_HI, 1'b0)) begin
                cyl_hi_q <= data_in;
            end
            if (hit(cs0_n_in, cs1_n_in, addr_in, `DDA_ADDR_DRVHEAD, 1'b0)) begin
                drvhead_q <= data_in;
            end
            // a write to the diagnostic address matches nothing here
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // command engine
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            state_q <= DDA_IDLE;
            result_q <= DDA_RES_OK;
            exec_cnt_q <= 4'h0;
            status_q <= `DDA_RST_STATUS;
            error_q <= `DDA_RST_ONE_BYTE;
        end else begin
            case (state_q)
                DDA_IDLE: begin
                    if (cmd_wr) begin
                        status_q[`DDA_ST_BSY] <= 1'b1;
                        status_q[`DDA_ST_ERR] <= 1'b0;
                        error_q <= `DDA_RST_BYTE;
                        exec_cnt_q <= `DDA_EXEC_CYCLES;
                        if (cmd_is_nop || !cmd_supported) begin
                            result_q <= DDA_RES_ABORT;
                            state_q <= DDA_DONE;
                        end else begin
                            result_q <= DDA_RES_OK;
                            state_q <= DDA_EXEC;
                        end
                    end
                end
                DDA_EXEC: begin
                    // stand-in for the real command work done elsewhere
                    exec_cnt_q <= exec_cnt_q - 4'h1;
                    if (exec_cnt_q == 4'h1) begin
                        state_q <= DDA_DONE;
                    end
                end
                DDA_DONE: begin
                    status_q[`DDA_ST_BSY] <= 1'b0;
                    status_q[`DDA_ST_DRDY] <= 1'b1;
                    if (result_q == DDA_RES_ABORT) begin
                        status_q[`DDA_ST_ERR] <= 1'b1;
                        error_q[`DDA_ER_ABORTED] <= 1'b1;
                    end
                    state_q <= DDA_IDLE;
                end
                default: state_q <= DDA_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt: completion sets, command write or status read clears
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            intrq_q <= 1'b0;
        end else if (state_q == DDA_DONE) begin
            intrq_q <= 1'b1;
        end else if (cmd_wr || (rd_stb_in && selected
                     && hit(cs0_n_in, cs1_n_in, addr_in, `DDA_ADDR_STATUS, 1'b0))) begin
            intrq_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read path: data registered, bus enabled for the cycle after the strobe
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            data_q <= `DDA_RST_BYTE;
            oe_q <= `DDA_RST_BYTE;
        end else begin
            data_q <= `DDA_RST_BYTE;
            oe_q <= `DDA_RST_BYTE;
            if (rd_stb_in && selected) begin
                oe_q <= 8'hFF;
                case ({cs1_n_in, cs0_n_in})
                    2'b10: begin
                        case (addr_in)
                            `DDA_ADDR_ERROR: data_q <= error_q;
                            `DDA_ADDR_COUNT: data_q <= count_q;
                            `DDA_ADDR_SECTOR: data_q <= sector_q;
                            `DDA_ADDR_CYL_LO: data_q <= cyl_lo_q;
                            `DDA_ADDR_CYL_HI: data_q <= cyl_hi_q;
                            `DDA_ADDR_DRVHEAD: data_q <= drvhead_q;
                            `DDA_ADDR_STATUS: data_q <= status_q;
                            default: oe_q <= `DDA_RST_BYTE;
                        endcase
                    end
                    2'b01: begin
                        case (addr_in)
                            `DDA_ADDR_ALTSTAT: data_q <= status_q;
                            `DDA_ADDR_DIAG: begin
                                data_q <= diag_byte;
                                oe_q <= 8'h7F;
                            end
                            default: oe_q <= `DDA_RST_BYTE;
                        endcase
                    end
                    default: oe_q <= `DDA_RST_BYTE;
                endcase
            end
        end
    end

    assign data_out = data_q;
    assign data_oe_out = oe_q;
    assign intrq_out = intrq_q;
    assign drive_head_select_reg_out = drvhead_q;
endmodule // dda_task_file

// ### verif/dda_task_file_assertions.sv
// dda_task_file_assertions.sv: port checks of the task-file top
// assumes: bound onto dda_task_file; host issues commands only while idle
module dda_task_file_assertions (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic cs0_n_in,
    input wire logic cs1_n_in,
    input wire logic [2:0] addr_in,
    input wire logic rd_stb_in,
    input wire logic wr_stb_in,
    input wire logic [7:0] data_in,
    input wire logic media_write_gate_n_in,
    input wire logic slave_cfg_in,
    input wire logic [7:0] data_out,
    input wire logic [7:0] data_oe_out,
    input wire logic intrq_out,
    input wire logic [7:0] drive_head_select_reg_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sel;
    logic diag_rd;
    logic cmd_wr;
    logic [3:0] head;
    assign sel = drive_head_select_reg_out[4] == slave_cfg_in;
    assign head = drive_head_select_reg_out[3:0];
    assign diag_rd = rd_stb_in && !cs1_n_in && cs0_n_in && addr_in == 3'h7 && sel;
    assign cmd_wr = wr_stb_in && !cs0_n_in && cs1_n_in && addr_in == 3'h7 && sel;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    ////////////////////////////////////////////////////////////////////////////
    diag_oe_mask_a: assert property (diag_rd |=> data_oe_out == 8'h7f)
        else $error("diag read enable wrong");
    diag_wgate_a: assert property (diag_rd |=> data_out[6] == $past(media_write_gate_n_in))
        else $error("diag write gate bit wrong");
    diag_head_a: assert property (diag_rd |=> ~data_out[5:2] == $past(head))
        else $error("diag head field wrong");
    diag_select_a: assert property (diag_rd |=> data_out[1:0] == ($past(slave_cfg_in) ? 2'b01 : 2'b10))
        else $error("diag select bits wrong");
    diag_read_only_a: assert property (wr_stb_in && !cs1_n_in && cs0_n_in && addr_in == 3'h7
        |=> $stable(drive_head_select_reg_out))
        else $error("diag write changed state");
    cmd_irq_clear_a: assert property (cmd_wr |=> !intrq_out)
        else $error("command write left irq set");
    nop_irq_a: assert property (cmd_wr && data_in == 8'h00 |=> !intrq_out ##1 intrq_out)
        else $error("nop completion irq wrong");
    nop_regs_kept_a: assert property (cmd_wr && data_in == 8'h00
        |=> $stable(drive_head_select_reg_out) [*2])
        else $error("nop changed drive head");
    idle_bus_a: assert property (!rd_stb_in |=> data_oe_out == 8'h00)
        else $error("bus driven without read");
    diag_c: cover property (diag_rd);
    nop_c: cover property (cmd_wr && data_in == 8'h00);
    irq_c: cover property ($rose(intrq_out));
endmodule // dda_task_file_assertions

// ### verif/dda_host_model.sv
// dda_host_model.sv: host controller driving the task-file strobes
// assumes: device samples on rising edge; model changes lines at falling edge
module dda_host_model (
    input wire logic clk_sys_in,
    input wire logic [7:0] rd_data_in,
    input wire logic [7:0] rd_oe_in,
    output logic cs0_n_out,
    output logic cs1_n_out,
    output logic [2:0] addr_out,
    output logic rd_stb_out,
    output logic wr_stb_out,
    output logic [7:0] wr_data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {cs0_n_out, cs1_n_out, addr_out, rd_stb_out, wr_stb_out} = 7'h60;
        wr_data_out = 8'h00;
    end
    // blk 0 picks the command block, 1 the control block
    task automatic rd(input logic blk, input logic [2:0] a, output logic [7:0] d,
                      output logic [7:0] oe);
        @(negedge clk_sys_in);
        {cs0_n_out, cs1_n_out, addr_out, rd_stb_out} = {blk, !blk, a, 1'b1};
        @(negedge clk_sys_in);
        {cs0_n_out, cs1_n_out, addr_out, rd_stb_out} = {2'b11, ~a, 1'b0};
        d = rd_data_in;
        oe = rd_oe_in;
    endtask
    // released data lines show the inverse, so stale values never look valid
    task automatic wr(input logic blk, input logic [2:0] a, input logic [7:0] d);
        @(negedge clk_sys_in);
        {cs0_n_out, cs1_n_out, addr_out, wr_stb_out, wr_data_out} = {blk, !blk, a, 1'b1, d};
        @(negedge clk_sys_in);
        {cs0_n_out, cs1_n_out, addr_out, wr_stb_out, wr_data_out} = {2'b11, ~a, 1'b0, ~d};
    endtask
    // ready reports whether the poll saw the drive idle and ready before the write
    task automatic cmd(input logic [7:0] code, output logic ready);
        logic [7:0] s;
        logic [7:0] oe;
        int n;
        n = 0;
        do begin
            rd(1'b1, 3'h6, s, oe);
            n++;
        end while ((s[7] || !s[6]) && n < 50);
        ready = !(s[7] || !s[6]);
        wr(1'b0, 3'h7, code);
    endtask
endmodule // dda_host_model

// ### verif/tb_dda_task_file.sv
// tb_dda_task_file.sv: directed test of diag register and command engine
// assumes: host model owns the bus lines; bench owns reset and drive state
module tb_dda_task_file;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_in, sys_rst_in, cs0_n_in, cs1_n_in, rd_stb_in, wr_stb_in;
    logic media_write_gate_n_in, slave_cfg_in, intrq_out, rdy;
    logic [2:0] addr_in;
    logic [7:0] data_in, data_out, data_oe_out, drive_head_select_reg_out, d, oe;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [7:0] codes [6] = '{8'h00, 8'h01, 8'h10, 8'h70, 8'h9a, 8'hff};
    logic [7:0] exp_st [6] = '{8'h51, 8'h51, 8'h50, 8'h50, 8'h51, 8'h51};
    dda_task_file i_dda_task_file (.clk_sys_in, .sys_rst_in, .cs0_n_in, .cs1_n_in,
        .addr_in, .rd_stb_in, .wr_stb_in, .data_in, .media_write_gate_n_in, .slave_cfg_in,
        .data_out, .data_oe_out, .intrq_out, .drive_head_select_reg_out);
    dda_host_model i_dda_host_model (.clk_sys_in, .rd_data_in(data_out), .rd_oe_in(data_oe_out),
        .cs0_n_out(cs0_n_in), .cs1_n_out(cs1_n_in), .addr_out(addr_in), .rd_stb_out(rd_stb_in),
        .wr_stb_out(wr_stb_in), .wr_data_out(data_in));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results;
        if (errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // completion can take the exec delay plus a few cycles
    task automatic wait_irq;
        for (int n = 0; n < 20 && intrq_out !== 1'b1; n++) @(negedge clk_sys_in);
    endtask
    task automatic do_reset;
        sys_rst_in = 1'b1;
        repeat (16) @(negedge clk_sys_in);
        sys_rst_in = 1'b0;
    endtask
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles >= 5000) begin
            errors++;
            results;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        media_write_gate_n_in = 1'b1;
        slave_cfg_in = 1'b0;
        do_reset;
        i_dda_host_model.rd(1'b0, 3'h7, d, oe);
        check("status reset", d, 8'h50);
        check("status enable", oe, 8'hff);
        i_dda_host_model.rd(1'b0, 3'h1, d, oe);
        check("error reset", d, 8'h01);
        for (int h = 0; h < 16; h++) begin
            i_dda_host_model.wr(1'b0, 3'h6, 8'ha0 | 8'(h));
            i_dda_host_model.rd(1'b1, 3'h7, d, oe);
            check("diag head", d, {2'b01, ~4'(h), 2'b10});
            check("diag enable", oe, 8'h7f);
        end
        media_write_gate_n_in = 1'b0;
        i_dda_host_model.rd(1'b1, 3'h7, d, oe);
        check("diag gate low", d, 8'h02);
        media_write_gate_n_in = 1'b1;
        i_dda_host_model.rd(1'b1, 3'h7, d, oe);
        check("diag gate high", d, 8'h42);
        i_dda_host_model.wr(1'b1, 3'h7, 8'h00);
        i_dda_host_model.rd(1'b1, 3'h7, d, oe);
        check("diag after write", d, 8'h42);
        check("drive head after diag write", drive_head_select_reg_out, 8'haf);
        i_dda_host_model.wr(1'b0, 3'h2, 8'h07);
        for (int i = 0; i < 6; i++) begin
            i_dda_host_model.cmd(codes[i], rdy);
            check("ready before command", {7'h00, rdy}, 8'h01);
            check("irq at command", {7'h00, intrq_out}, 8'h00);
            wait_irq;
            check("irq at completion", {7'h00, intrq_out}, 8'h01);
            i_dda_host_model.rd(1'b1, 3'h6, d, oe);
            check("alt status", d, exp_st[i]);
            i_dda_host_model.rd(1'b0, 3'h1, d, oe);
            check("error", d, exp_st[i][0] ? 8'h04 : 8'h00);
            check("irq kept", {7'h00, intrq_out}, 8'h01);
            i_dda_host_model.rd(1'b0, 3'h2, d, oe);
            check("count kept", d, 8'h07);
            check("drive head kept", drive_head_select_reg_out, 8'haf);
        end
        i_dda_host_model.rd(1'b0, 3'h7, d, oe);
        check("status", d, 8'h51);
        @(negedge clk_sys_in);
        check("irq acknowledged", {7'h00, intrq_out}, 8'h00);
        slave_cfg_in = 1'b1;
        do_reset;
        i_dda_host_model.rd(1'b1, 3'h7, d, oe);
        check("unselected enable", oe, 8'h00);
        // a deselected drive must ignore the command write
        i_dda_host_model.wr(1'b0, 3'h7, 8'h00);
        repeat (3) @(negedge clk_sys_in);
        check("unselected command irq", {7'h00, intrq_out}, 8'h00);
        i_dda_host_model.wr(1'b0, 3'h6, 8'hb3);
        i_dda_host_model.rd(1'b1, 3'h6, d, oe);
        check("unselected command status", d, 8'h50);
        i_dda_host_model.rd(1'b1, 3'h7, d, oe);
        check("slave diag", d, 8'h71);
        results;
    end
endmodule // tb_dda_task_file

bind dda_task_file dda_task_file_assertions i_dda_task_file_assertions (.clk_sys_in,
    .sys_rst_in, .cs0_n_in, .cs1_n_in, .addr_in, .rd_stb_in, .wr_stb_in, .data_in,
    .media_write_gate_n_in, .slave_cfg_in, .data_out, .data_oe_out, .intrq_out,
    .drive_head_select_reg_out);
